// >>> hdl/rhc_host.sv
// How it works
// RL1 - 28 registers, 7-bit address in frame
// RL2 - frame is address, select bit, data
// RL3 - address sent most significant bit first
// RL4 - select high writes, low reads back
// RL5 - latch enable low over address, select
// RL6 - device captures data on falling edge
// RL7 - device stores byte after last bit
// RL8 - device keeps registers in power-down
// RL9 - any write order, all registers readable
// RL10 - host releases data line during read
// RL11 - latch enable high makes pins ignored
// RL12 - latch enable high in power-down
// RL13 - drive pins to defined levels powered down; latch enable is released to its pull-up instead
// RL14 - lock pin high while loop locked
// RL15 - transmit bits sampled at rising clock
// RL16 - device offers eight NRZ rates
// RL17 - top rates need the nominal crystal
// RL18 - host samples receive data at rising edge
// RL19 - host sends plain bits in Manchester
// RL20 - device decodes Manchester on receive
// RL21 - device offers eight Manchester rates
// RL22 - UART mode modulates line directly
// RL23 - UART receive data on clock pin
// RL24 - UART accepts any rate in range
// RL25 - zero rises, one falls in chip
// RL26 - violation flag routable to lock pin
// RL27 - latch enable high between frames
// RL28 - one data clock per bit
//
// Purpose: host controller for a radio configuration and data port
// Assumes: 100 MHz clk_in; radio_data_clock comes from the device
// Notes: configuration clock made here by a divider
`timescale 1ns/1ps
`include "rhc_consts.svh"
module rhc_host (
    input wire logic clk_in,
    input wire logic rst_in,
    // user command port
    input wire logic cmd_valid_in,
    input wire rhc_pkg::rhc_cmd_t cmd_in,
    output logic cmd_ready_out,
    output logic rd_valid_out,
    output logic [7:0] rd_data_out,
    input wire logic power_down_in,
    input wire rhc_pkg::rhc_mode_t mode_in,
    input wire logic top_rate_ok_in,
    // user data port
    input wire logic tx_valid_in,
    input wire logic tx_bit_in,
    output logic tx_ready_out,
    output logic rx_valid_out,
    output logic rx_bit_out,
    output logic lock_out,
    // device configuration pins
    output logic config_serial_clk_out,
    output logic config_serial_data_out,
    output logic config_serial_data_oe_out,
    input wire logic config_serial_data_in,
    output logic config_address_latch_n_out,
    output logic config_address_latch_n_oe_out,
    // device data pins
    input wire logic radio_data_clock,
    input wire logic radio_data_clock_in,
    output logic radio_data_line_out,
    output logic radio_data_line_oe_out,
    input wire logic radio_data_line_in,
    input wire logic lock_indicator_pin_in
);
    ////////////////////////////////////////////////////////////////////////
    // configuration frame engine
    rhc_pkg::rhc_state_t state_q;
    logic [`RHC_HALF_W-1:0] half_q;
    logic [4:0] bit_q;
    logic [15:0] shift_q;
    logic write_q;
    logic [7:0] rd_shift_q;
    logic config_serial_data_s;
    logic half_done;

    assign half_done = (half_q == `RHC_HALF_W'(`RHC_HALF_CYC - 1));
    // out of range addresses are refused; device holds only 28
    assign cmd_ready_out = (state_q == rhc_pkg::RHC_ST_IDLE) &&
                           (cmd_in.addr < `RHC_REG_COUNT); // [RL1]

    rhc_sync u_config_serial_data_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(config_serial_data_in),
        .q_out(config_serial_data_s)
    );

    // phase counter for the divided configuration clock
    always_ff @(posedge clk_in) begin
        if (rst_in || state_q == rhc_pkg::RHC_ST_IDLE || half_done) begin
            half_q <= `RHC_ZERO4;
        end else begin
            half_q <= half_q + 1'b1;
        end
    end

    // frame sequencer: clock high phase then low phase per bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= rhc_pkg::RHC_ST_IDLE;
            bit_q <= `RHC_ZERO5;
            shift_q <= 16'h0000;
            write_q <= 1'b0;
        end else begin
            case (state_q)
                rhc_pkg::RHC_ST_IDLE: begin
                    if (cmd_valid_in && cmd_ready_out) begin
                        shift_q <= cmd_in; // [RL2] [RL3] [RL4] [RL9]
                        write_q <= cmd_in.write;
                        bit_q <= `RHC_ZERO5;
                        state_q <= rhc_pkg::RHC_ST_HIGH;
                    end
                end
                rhc_pkg::RHC_ST_HIGH: begin
                    if (half_done) begin
                        state_q <= rhc_pkg::RHC_ST_LOW;
                    end
                end
                rhc_pkg::RHC_ST_LOW: begin
                    // falling edge just passed: device took the bit [RL6]
                    if (half_done) begin
                        shift_q <= {shift_q[14:0], 1'b0};
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == `RHC_FRAME_BITS - 1'b1) begin
                            state_q <= rhc_pkg::RHC_ST_DONE; // [RL7]
                        end else begin
                            state_q <= rhc_pkg::RHC_ST_HIGH;
                        end
                    end
                end
                rhc_pkg::RHC_ST_DONE: begin
                    if (half_done) begin
                        state_q <= rhc_pkg::RHC_ST_IDLE; // [RL27]
                    end
                end
                default: begin
                    state_q <= rhc_pkg::RHC_ST_IDLE;
                end
            endcase
        end
    end

    // pin drive, registered
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            config_serial_clk_out <= 1'b1;
            config_serial_data_out <= 1'b0;
            config_serial_data_oe_out <= 1'b1;
            config_address_latch_n_out <= 1'b1;
            config_address_latch_n_oe_out <= 1'b1;
        end else begin
            config_serial_clk_out <= (state_q != rhc_pkg::RHC_ST_LOW);
            config_serial_data_out <= (state_q == rhc_pkg::RHC_ST_IDLE) ?
                                      1'b0 : shift_q[15]; // [RL13]
            // release the line for read-back data bits
            config_serial_data_oe_out <= !((state_q == rhc_pkg::RHC_ST_HIGH ||
                                            state_q == rhc_pkg::RHC_ST_LOW) &&
                                           !write_q &&
                                           bit_q >= `RHC_DATA_START); // [RL10]
            // low over address and select bit, high otherwise
            config_address_latch_n_out <= !((state_q == rhc_pkg::RHC_ST_HIGH ||
                                             state_q == rhc_pkg::RHC_ST_LOW) &&
                                            bit_q < `RHC_DATA_START); // [RL5] [RL11]
            // in power-down release the pin to its pull-up
            config_address_latch_n_oe_out <= !(power_down_in &&
                                               state_q == rhc_pkg::RHC_ST_IDLE); // [RL12]
        end
    end

    // read-back capture near the end of the low phase of each data bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_shift_q <= `RHC_ZERO8;
            rd_valid_out <= 1'b0;
            rd_data_out <= `RHC_ZERO8;
        end else begin
            rd_valid_out <= 1'b0;
            if (state_q == rhc_pkg::RHC_ST_LOW && half_done && !write_q &&
                bit_q >= `RHC_DATA_START) begin
                rd_shift_q <= {rd_shift_q[6:0], config_serial_data_s}; // [RL10]
            end
            if (state_q == rhc_pkg::RHC_ST_DONE && half_done && !write_q) begin
                rd_data_out <= rd_shift_q;
                rd_valid_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data port: crossing into the radio data clock domain
    logic tx_toggle_q;
    logic tx_bit_q;
    logic ack_toggle;
    logic ack_s;
    logic line_tx;
    logic rx_bit_link;
    logic rx_toggle_link;
    logic rx_toggle_s;
    logic rx_toggle_seen_q;
    logic rx_bit_s;
    logic lock_s;
    logic uart_s;
    logic tx_mode;
    logic top_rate_bad;
    logic [3:0] line_hold_q;

    assign tx_mode = tx_valid_in || (tx_toggle_q != ack_s);
    // top rates are held off unless the crystal is confirmed
    assign top_rate_bad = !top_rate_ok_in; // [RL17]
    assign tx_ready_out = (tx_toggle_q == ack_s) && !power_down_in && !top_rate_bad;

    rhc_link u_link (
        .link_clk_in(radio_data_clock),
        .rst_in(rst_in),
        .tx_toggle_in(tx_toggle_q),
        .tx_bit_in(tx_bit_q),
        .rx_data_in(radio_data_line_in),
        .tx_ack_toggle_out(ack_toggle),
        .tx_line_out(line_tx),
        .rx_bit_out(rx_bit_link),
        .rx_toggle_out(rx_toggle_link)
    );

    rhc_sync u_ack_sync (
        .clk_in(clk_in), .rst_in(rst_in), .d_in(ack_toggle), .q_out(ack_s)
    );
    rhc_sync u_rxt_sync (
        .clk_in(clk_in), .rst_in(rst_in), .d_in(rx_toggle_link), .q_out(rx_toggle_s)
    );
    rhc_sync u_rxb_sync (
        .clk_in(clk_in), .rst_in(rst_in), .d_in(rx_bit_link), .q_out(rx_bit_s)
    );
    rhc_sync u_lock_sync (
        .clk_in(clk_in), .rst_in(rst_in), .d_in(lock_indicator_pin_in), .q_out(lock_s)
    );
    rhc_sync u_uart_sync (
        .clk_in(clk_in), .rst_in(rst_in), .d_in(radio_data_clock_in), .q_out(uart_s)
    );

    // transmit request: one toggle per bit, held until acknowledged
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_toggle_q <= 1'b0;
            tx_bit_q <= 1'b0;
        end else if (tx_valid_in && tx_ready_out) begin
            tx_bit_q <= tx_bit_in; // [RL19] plain bits; device encodes
            tx_toggle_q <= ~tx_toggle_q;
        end
    end

    // receive: one bit per recovered clock, or raw level in uart mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_toggle_seen_q <= 1'b0;
            rx_valid_out <= 1'b0;
            rx_bit_out <= 1'b0;
            lock_out <= 1'b0;
        end else begin
            rx_toggle_seen_q <= rx_toggle_s;
            lock_out <= lock_s; // [RL14] [RL26]
            if (mode_in == rhc_pkg::RHC_MODE_UART) begin
                rx_bit_out <= uart_s; // [RL23]
                rx_valid_out <= 1'b1;
            end else begin
                rx_valid_out <= (rx_toggle_s != rx_toggle_seen_q); // [RL18]
                rx_bit_out <= rx_bit_s;
            end
        end
    end

    // the ack comes back before the device's sampling edge, so keep driving a while
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            line_hold_q <= `RHC_ZERO4;
        end else if (tx_mode) begin
            line_hold_q <= `RHC_LINE_HOLD;
        end else if (line_hold_q != `RHC_ZERO4) begin
            line_hold_q <= line_hold_q - 1'b1;
        end
    end

    // data line drive: uart passes the level straight through
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            radio_data_line_out <= 1'b0;
            radio_data_line_oe_out <= 1'b1;
        end else begin
            radio_data_line_oe_out <= tx_mode || (line_hold_q != `RHC_ZERO4) ||
                                      power_down_in; // [RL13] [RL15]
            if (power_down_in) begin
                radio_data_line_out <= 1'b0;
            end else if (mode_in == rhc_pkg::RHC_MODE_UART) begin
                radio_data_line_out <= tx_bit_in; // [RL22]
            end else begin
                radio_data_line_out <= line_tx;
            end
        end
    end
endmodule : rhc_host

// >>> hdl/rhc_consts.svh
// Purpose: named constants for the radio host controller
// Assumes: 100 MHz system clock
// Notes: frame layout and serial clock timing
`ifndef RHC_CONSTS_SVH
`define RHC_CONSTS_SVH
`define RHC_FRAME_BITS 5'h10
`define RHC_ADDR_BITS 7
`define RHC_REG_COUNT 7'h1c
`define RHC_RW_WRITE 1'b1
`define RHC_RW_READ 1'b0
// half period of the configuration clock, 50 ns each phase
`define RHC_HALF_NS 50
`define RHC_CLK_NS 10
`define RHC_HALF_CYC ((`RHC_HALF_NS + `RHC_CLK_NS - 1) / `RHC_CLK_NS)
`define RHC_HALF_W 4
`define RHC_DATA_START 5'h08
`define RHC_ZERO4 4'h0
// cycles the data line stays driven after the ack, longer than half a link period
`define RHC_LINE_HOLD 4'hc
`define RHC_ZERO5 5'h00
`define RHC_ZERO8 8'h00
`endif

// >>> hdl/rhc_pkg.sv
// Purpose: shared types for the radio host controller
// Assumes: included constants header
// Notes: types only
package rhc_pkg;
    typedef enum logic [1:0] {
        RHC_MODE_NRZ = 2'h0,
        RHC_MODE_MAN = 2'h1,
        RHC_MODE_UART = 2'h2
    } rhc_mode_t;

    typedef struct packed {
        logic [6:0] addr;
        logic write;
        logic [7:0] data;
    } rhc_cmd_t;

    typedef enum logic [1:0] {
        RHC_ST_IDLE = 2'b00,
        RHC_ST_LOW = 2'b01,
        RHC_ST_HIGH = 2'b11,
        RHC_ST_DONE = 2'b10
    } rhc_state_t;
endpackage : rhc_pkg

// >>> hdl/rhc_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input asynchronous to clk_in
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module rhc_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_q;

    // plain two-stage chain
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : rhc_sync

// >>> hdl/rhc_link.sv
// Purpose: data port logic on the radio data clock domain
// Assumes: radio_data_clock is made by the device
// Notes: one bit per clock, handshake with the system domain
`timescale 1ns/1ps
module rhc_link (
    input wire logic link_clk_in,
    input wire logic rst_in,
    input wire logic tx_toggle_in,
    input wire logic tx_bit_in,
    input wire logic rx_data_in,
    output logic tx_ack_toggle_out,
    output logic tx_line_out,
    output logic rx_bit_out,
    output logic rx_toggle_out
);
    logic tx_t1_q;
    logic tx_t2_q;
    logic rst_s1_q;
    logic rst_s2_q;

    // reset is brought into this domain; clock may stop, so state is kept
    always_ff @(posedge link_clk_in) begin
        rst_s1_q <= rst_in;
        rst_s2_q <= rst_s1_q;
    end

    // request toggle crosses by two flip-flops
    always_ff @(posedge link_clk_in) begin
        tx_t1_q <= tx_toggle_in;
        tx_t2_q <= tx_t1_q;
    end

    // device samples the line at rising edge, so launch on the falling side
    always_ff @(negedge link_clk_in) begin
        if (rst_s2_q) begin
            tx_line_out <= 1'b0;
            tx_ack_toggle_out <= 1'b0;
        end else if (tx_t2_q != tx_ack_toggle_out) begin
            tx_line_out <= tx_bit_in; // [RL15] [RL19]
            tx_ack_toggle_out <= tx_t2_q;
        end
    end

    // receive sample at each rising edge, one bit per period
    always_ff @(posedge link_clk_in) begin
        if (rst_s2_q) begin
            rx_bit_out <= 1'b0;
            rx_toggle_out <= 1'b0;
        end else begin
            rx_bit_out <= rx_data_in; // [RL18] [RL28]
            rx_toggle_out <= ~rx_toggle_out;
        end
    end
endmodule : rhc_link

// >>> testbench/rhc_host_properties.sv
// Purpose: concurrent checks on the radio host controller ports
// Assumes: system clock domain only, sync active-high reset
// Notes: bound to rhc_host after the module
`timescale 1ns/1ps
module rhc_host_properties (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire rhc_pkg::rhc_cmd_t cmd_in,
    input wire logic cmd_ready_out,
    input wire logic rd_valid_out,
    input wire logic power_down_in,
    input wire logic top_rate_ok_in,
    input wire logic tx_ready_out,
    input wire logic lock_out,
    input wire logic config_serial_clk_out,
    input wire logic config_serial_data_oe_out,
    input wire logic config_address_latch_n_out,
    input wire logic config_address_latch_n_oe_out,
    input wire logic lock_indicator_pin_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////
    // frame framing and serial clock shape
    a_range_refused: assert property (cmd_in.addr >= 7'h1c |-> !cmd_ready_out)
        else $error("address beyond the register file accepted");
    a_take_latch: assert property (cmd_valid_in && cmd_ready_out |-> ##[1:3] !config_address_latch_n_out)
        else $error("latch enable not lowered after a take");
    a_latch_hold: assert property ($fell(config_address_latch_n_out) |-> !config_address_latch_n_out [*8])
        else $error("latch enable released too early");
    a_low_half: assert property ($fell(config_serial_clk_out) |-> !config_serial_clk_out [*5] ##1 config_serial_clk_out)
        else $error("serial clock low phase not five cycles");
    a_high_half: assert property ($rose(config_serial_clk_out) |-> config_serial_clk_out [*5])
        else $error("serial clock high phase too short");
    a_release_data: assert property (!config_serial_data_oe_out |-> config_address_latch_n_out)
        else $error("data line released in the address phase");
    a_rd_pulse: assert property (rd_valid_out |=> !rd_valid_out)
        else $error("read valid longer than one cycle");
    a_idle_latch: assert property (cmd_ready_out && !power_down_in |-> config_address_latch_n_out)
        else $error("latch enable low while idle");
    // data port refusals, power-down pins and lock
    a_tx_refused: assert property (power_down_in || !top_rate_ok_in |-> !tx_ready_out)
        else $error("transmit offered while refused");
    a_pd_release: assert property (power_down_in [*4] ##0 cmd_ready_out |-> !config_address_latch_n_oe_out)
        else $error("latch pin still driven in power-down");
    a_lock_follow: assert property (lock_indicator_pin_in [*5] |-> lock_out)
        else $error("lock output does not follow the pin");
    cover property (cmd_valid_in && cmd_ready_out && cmd_in.write);
    cover property (cmd_valid_in && cmd_ready_out && !cmd_in.write);
    cover property (power_down_in [*4]);
endmodule : rhc_host_properties

bind rhc_host rhc_host_properties i_rhc_host_properties (
    .clk_in, .rst_in, .cmd_valid_in, .cmd_in, .cmd_ready_out, .rd_valid_out,
    .power_down_in, .top_rate_ok_in, .tx_ready_out, .lock_out, .config_serial_clk_out,
    .config_serial_data_oe_out, .config_address_latch_n_out,
    .config_address_latch_n_oe_out, .lock_indicator_pin_in
);

// >>> testbench/rhc_dev_model.sv
// Purpose: behavioural radio device facing the host controller
// Assumes: bench sets the lock level
// Notes: one fixed bit rate; modulation not modelled
`timescale 1ns/1ps
module rhc_dev_model #(
    parameter int NREG = 28
) (
    input wire logic sclk_in,
    input wire logic cfg_data_in,
    input wire logic cfg_data_oe_in,
    input wire logic latch_n_in,
    input wire logic latch_n_oe_in,
    input wire logic pd_in,
    input wire logic line_in,
    input wire logic line_oe_in,
    input wire logic lock_set_in,
    output logic cfg_data_out,
    output logic radio_data_clock_out,
    output logic line_out,
    output logic lock_out
);
    logic [7:0] regs [NREG];
    logic [7:0] rd;
    logic [15:0] sh;
    logic [4:0] cnt = 5'h10;
    logic rw = 1'b1, drv = 1'b0, dbit = 1'b0, rxb = 1'b0, tx_last = 1'b0;
    // an open latch pin floats high through the pull-up
    wire latch_n = latch_n_oe_in ? latch_n_in : 1'b1;
    // a released line the device does not drive shows the inverse, so a stale value never passes
    assign cfg_data_out = cfg_data_oe_in ? cfg_data_in : (drv ? dbit : ~dbit);
    assign line_out = line_oe_in ? line_in : rxb;
    assign lock_out = lock_set_in;
    ////////////////////////////////////////////////////////////////
    // registers survive power-down; only the frame counter restarts
    initial foreach (regs[i]) regs[i] = 8'h00;
    always @(negedge latch_n) cnt = 5'h00;
    // falling-edge capture; pins ignored once sixteen bits are in
    always @(negedge sclk_in) begin
        if (cnt < 5'h10) begin
            sh = {sh[14:0], cfg_data_out};
            cnt = cnt + 5'h01;
            if (cnt == 5'h08) rw = sh[0];
            if (cnt == 5'h08 && !rw) rd = (sh[7:1] < NREG) ? regs[sh[7:1]] : 8'h00;
            // each data bit is put out at the falling edge that opens its low phase
            drv = !rw && cnt >= 5'h09;
            if (drv) dbit = rd[5'h10 - cnt];
            if (cnt == 5'h10 && rw && sh[15:9] < NREG) regs[sh[15:9]] = sh[7:0];
        end
    end
    // link clock stands still in power-down, phase unrelated to clk_in
    initial begin
        radio_data_clock_out = 1'b0;
        #3;
        // one fixed rate from the allowed set; the same pin carries raw uart data
        forever #40 radio_data_clock_out = pd_in ? 1'b0 : ~radio_data_clock_out;
    end
    always @(negedge radio_data_clock_out) rxb <= ~rxb;
    // chip encoding is internal; the host only ever sees plain bits
    always @(posedge radio_data_clock_out) if (line_oe_in) tx_last <= line_in;
endmodule : rhc_dev_model

// >>> testbench/tb.sv
// Purpose: self-checking bench for the radio host controller
// Assumes: device model on the far side
// Notes: reset held long enough for the link side to see it
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, power_down_in = 1'b0;
    logic top_rate_ok_in = 1'b1, tx_valid_in = 1'b0, tx_bit_in = 1'b0, lock_set = 1'b0;
    rhc_pkg::rhc_cmd_t cmd_in = '0;
    rhc_pkg::rhc_mode_t mode_in = rhc_pkg::RHC_MODE_NRZ;
    logic cmd_ready_out, rd_valid_out, tx_ready_out, rx_valid_out, rx_bit_out, lock_out;
    logic config_serial_clk_out, config_serial_data_out, config_serial_data_oe_out;
    logic config_serial_data_in, config_address_latch_n_out, config_address_latch_n_oe_out;
    logic radio_data_clock, radio_data_line_out, radio_data_line_oe_out;
    logic radio_data_line_in, lock_indicator_pin_in;
    logic [7:0] rd_data_out;
    logic [6:0] ad [3] = '{7'h1b, 7'h00, 7'h0d};
    logic [7:0] dv [3] = '{8'ha5, 8'h3c, 8'h81};
    int err_total = 0, compares = 0;

    rhc_host i_rhc_host (.clk_in, .rst_in, .cmd_valid_in, .cmd_in, .cmd_ready_out,
        .rd_valid_out, .rd_data_out, .power_down_in, .mode_in, .top_rate_ok_in,
        .tx_valid_in, .tx_bit_in, .tx_ready_out, .rx_valid_out, .rx_bit_out, .lock_out,
        .config_serial_clk_out, .config_serial_data_out, .config_serial_data_oe_out,
        .config_serial_data_in, .config_address_latch_n_out, .config_address_latch_n_oe_out,
        .radio_data_clock, .radio_data_clock_in(radio_data_clock), .radio_data_line_out,
        .radio_data_line_oe_out, .radio_data_line_in, .lock_indicator_pin_in);
    rhc_dev_model i_rhc_dev_model (.sclk_in(config_serial_clk_out),
        .cfg_data_in(config_serial_data_out), .cfg_data_oe_in(config_serial_data_oe_out),
        .latch_n_in(config_address_latch_n_out), .latch_n_oe_in(config_address_latch_n_oe_out),
        .pd_in(power_down_in), .line_in(radio_data_line_out),
        .line_oe_in(radio_data_line_oe_out), .lock_set_in(lock_set),
        .cfg_data_out(config_serial_data_in), .radio_data_clock_out(radio_data_clock),
        .line_out(radio_data_line_in), .lock_out(lock_indicator_pin_in));
    ////////////////////////////////////////////////////////////////
    initial forever #5 clk_in = ~clk_in;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one frame; waits for the take, and for read data on a read
    task automatic cfg(input logic [6:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_in <= {a, w, d};
        cmd_valid_in <= 1'b1;
        do @(posedge clk_in); while (cmd_ready_out !== 1'b1 && ++n < 400);
        cmd_valid_in <= 1'b0;
        do @(posedge clk_in); while (!w && rd_valid_out !== 1'b1 && ++n < 800);
        if (n >= 400) err_total++;
        q = rd_data_out;
    endtask : cfg

    // one transmit bit, then the device's next rising-clock sample
    task automatic tx(input logic b);
        int n;
        n = 0;
        @(posedge clk_in);
        tx_bit_in <= b;
        tx_valid_in <= 1'b1;
        do @(posedge clk_in); while (tx_ready_out !== 1'b1 && ++n < 200);
        tx_valid_in <= 1'b0;
        do @(posedge clk_in); while (tx_ready_out !== 1'b1 && ++n < 200);
        @(posedge radio_data_clock);
        #1;
        check("tx bit", {7'h00, i_rhc_dev_model.tx_last}, {7'h00, b});
    endtask : tx

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    initial begin
        logic [7:0] q;
        // longer than two cycles so the link domain sees three edges
        repeat (24) @(posedge clk_in);
        check("latch idle", {7'h00, config_address_latch_n_out}, 8'h01);
        rst_in <= 1'b0;
        foreach (ad[i]) cfg(ad[i], 1'b1, dv[i], q);
        // let the last write frame run to its end
        repeat (200) @(posedge clk_in);
        foreach (ad[i]) check("stored", i_rhc_dev_model.regs[ad[i]], dv[i]);
        for (int i = 2; i >= 0; i--) begin
            cfg(ad[i], 1'b0, 8'h00, q);
            check("read back", q, dv[i]);
        end
        cmd_in <= {7'h1c, 1'b1, 8'hff};
        cmd_valid_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check("ready high addr", {7'h00, cmd_ready_out}, 8'h00);
        cmd_valid_in <= 1'b0;
        cmd_in <= '0;
        $display("test config done");
        lock_set <= 1'b1;
        repeat (8) @(posedge clk_in);
        check("lock set", {7'h00, lock_out}, 8'h01);
        lock_set <= 1'b0;
        repeat (8) @(posedge clk_in);
        check("lock clear", {7'h00, lock_out}, 8'h00);
        $display("test lock done");
        power_down_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        check("pd tx ready", {7'h00, tx_ready_out}, 8'h00);
        check("pd latch oe", {7'h00, config_address_latch_n_oe_out}, 8'h00);
        power_down_in <= 1'b0;
        top_rate_ok_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("rate tx ready", {7'h00, tx_ready_out}, 8'h00);
        top_rate_ok_in <= 1'b1;
        cfg(ad[0], 1'b0, 8'h00, q);
        check("kept in pd", q, dv[0]);
        $display("test power-down done");
        for (int m = 0; m < 3; m++) begin
            mode_in <= rhc_pkg::rhc_mode_t'(m[1:0]);
            foreach (dv[i]) tx(dv[i][m]);
            tx(1'b1);
            tx(1'b0);
        end
        $display("test transmit done");
        // model toggles its receive bit every link period
        mode_in <= rhc_pkg::RHC_MODE_NRZ;
        repeat (40) @(posedge clk_in);
        do @(posedge clk_in); while (rx_valid_out !== 1'b1);
        q[0] = rx_bit_out;
        @(posedge clk_in);
        do @(posedge clk_in); while (rx_valid_out !== 1'b1);
        check("rx bit", {7'h00, rx_bit_out}, {7'h00, ~q[0]});
        $display("test receive done");
        finish_test();
    end
endmodule : tb
